// *** logic/scfc_stab_cfg.v ***
// Stabilization chain filter configuration registers, shared by two ports
`timescale 1ns/1ps
`include "scfc_defines.vh"
module scfc_stab_cfg #(
  parameter DW = 16 // Chain sample width
) (
  input wire sys_clk, // System clock
  input wire srst, // Synchronous reset, active high
  input wire primary_port_owns_stab, // 1: primary port has full control
  input wire pri_wr, // Primary port write strobe
  input wire [7:0] pri_addr, // Primary port address
  input wire [7:0] pri_wdata, // Primary port write data
  output wire [7:0] pri_rdata, // Primary port read data
  input wire aux_wr, // Auxiliary port write strobe
  input wire [7:0] aux_addr, // Auxiliary port address
  input wire [7:0] aux_wdata, // Auxiliary port write data
  output wire [7:0] aux_rdata, // Auxiliary port read data
  input wire accel_scale_mode, // Full-scale mode bit of main accel
  input wire main_accel_on, // Main accelerometer powered
  input wire [1:0] main_accel_fs, // Main-interface full scale code
  input wire gyro_stab_processing_en, // Gyro stabilization processing on
  input wire selftest_active, // Self-test in progress
  input wire [DW-1:0] gyro_raw, // Gyro chain sample before clamp
  input wire [DW-1:0] accel_raw, // Accel chain sample before clamp
  output reg [DW-1:0] gyro_out, // Gyro chain output
  output reg [DW-1:0] accel_out, // Accel chain output
  output reg gyro_highpass_enable, // High-pass filter applied
  output reg [1:0] gyro_highpass_cutoff, // High-pass cutoff select
  output reg [1:0] gyro_lowpass_bw, // Low-pass bandwidth select
  output reg first_lowpass_stage_to_stab, // First low-pass stage given to chain
  output reg [2:0] accel_stab_bandwidth, // Accel bandwidth select
  output reg [1:0] accel_fs_eff // Effective accel full scale code
);
  // Sign bit alone: the clamp word scales with the sample width
  localparam [DW-1:0] CLAMP_WORD = {1'b1, {(DW-1){1'b0}}};
  localparam NUM_CHAN = 2;
  localparam CH_GYRO = 0;
  localparam CH_ACCEL = 1;

  reg [7:0] gyro_filt_ff;
  reg [7:0] accel_cfg_ff;
  reg [7:0] nxt_gyro_filt;
  reg [7:0] nxt_accel_cfg;
  reg [1:0] nxt_fs;
  reg [1:0] fs_pd_code;
  reg [1:0] fs_lock_code;
  wire pri_we;
  wire aux_we;
  wire pri_hit_gyro;
  wire pri_hit_accel;
  wire aux_hit_gyro;
  wire aux_hit_accel;
  wire [1:0] fs_field;
  wire clamp;
  wire [DW-1:0] chan_raw [0:NUM_CHAN-1];
  wire [DW-1:0] chan_nxt [0:NUM_CHAN-1];

  // Ownership decides which port may write; the other reads the same copy
  assign pri_we = pri_wr & primary_port_owns_stab;
  assign aux_we = aux_wr & ~primary_port_owns_stab;

  assign pri_hit_gyro = pri_we & (pri_addr == `SCFC_ADDR_GYRO_FILT);
  assign pri_hit_accel = pri_we & (pri_addr == `SCFC_ADDR_ACCEL_CFG);
  assign aux_hit_gyro = aux_we & (aux_addr == `SCFC_ADDR_GYRO_FILT);
  assign aux_hit_accel = aux_we & (aux_addr == `SCFC_ADDR_ACCEL_CFG);

  // Reserved bits masked so a stray write cannot reach them
  always @* begin
    nxt_gyro_filt = gyro_filt_ff;
    if (pri_hit_gyro) begin
      nxt_gyro_filt = pri_wdata & `SCFC_GYRO_WMASK;
    end else if (aux_hit_gyro) begin
      nxt_gyro_filt = aux_wdata & `SCFC_GYRO_WMASK;
    end
  end

  always @* begin
    nxt_accel_cfg = accel_cfg_ff;
    if (pri_hit_accel) begin
      nxt_accel_cfg = pri_wdata & `SCFC_ACCEL_WMASK;
    end else if (aux_hit_accel) begin
      nxt_accel_cfg = aux_wdata & `SCFC_ACCEL_WMASK;
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      gyro_filt_ff <= `SCFC_RST_VAL;
    end else begin
      gyro_filt_ff <= nxt_gyro_filt;
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      accel_cfg_ff <= `SCFC_RST_VAL;
    end else begin
      accel_cfg_ff <= nxt_accel_cfg;
    end
  end

  assign fs_field = accel_cfg_ff[`SCFC_XL_FS_LSB +: 2];

  // Range table while the scale-mode bit is clear and main accel sleeps
  always @* begin
    fs_pd_code = `SCFC_FS_2G;
    case (fs_field)
      2'h0: begin
        fs_pd_code = `SCFC_FS_2G;
      end
      2'h1: begin
        fs_pd_code = `SCFC_FS_16G;
      end
      2'h2: begin
        fs_pd_code = `SCFC_FS_4G;
      end
      2'h3: begin
        fs_pd_code = `SCFC_FS_8G;
      end
      default: begin
        fs_pd_code = `SCFC_FS_2G;
      end
    endcase
  end

  // Range table while the scale-mode bit is set; 16 g is not reachable
  always @* begin
    fs_lock_code = `SCFC_FS_2G;
    case (fs_field)
      2'h0: begin
        fs_lock_code = `SCFC_FS_2G;
      end
      2'h1: begin
        fs_lock_code = `SCFC_FS_2G;
      end
      2'h2: begin
        fs_lock_code = `SCFC_FS_4G;
      end
      2'h3: begin
        fs_lock_code = `SCFC_FS_8G;
      end
      default: begin
        fs_lock_code = `SCFC_FS_2G;
      end
    endcase
  end

  always @* begin
    nxt_fs = fs_pd_code;
    if (accel_scale_mode) begin
      nxt_fs = fs_lock_code;
    end else if (main_accel_on) begin
      // Main side owns the range; mirror it so the chain reports it too
      nxt_fs = main_accel_fs;
    end
  end

  // Unmapped addresses read zero
  function [7:0] rd_mux;
    input [7:0] addr;
    begin
      if (addr == `SCFC_ADDR_GYRO_FILT)
        rd_mux = gyro_filt_ff;
      else if (addr == `SCFC_ADDR_ACCEL_CFG)
        rd_mux = accel_cfg_ff;
      else
        rd_mux = 8'h00;
    end
  endfunction

  assign pri_rdata = rd_mux(pri_addr);
  assign aux_rdata = rd_mux(aux_addr);

  assign clamp = selftest_active &
    ~accel_cfg_ff[`SCFC_CLAMP_DIS_BIT];

  assign chan_raw[CH_GYRO] = gyro_raw;
  assign chan_raw[CH_ACCEL] = accel_raw;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch = ch + 1) begin : g_chan
      assign chan_nxt[ch] = clamp ? CLAMP_WORD : chan_raw[ch];
    end
  endgenerate

  always @(posedge sys_clk) begin
    if (srst) begin
      gyro_out <= {DW{1'b0}};
      accel_out <= {DW{1'b0}};
    end else begin
      gyro_out <= chan_nxt[CH_GYRO];
      accel_out <= chan_nxt[CH_ACCEL];
    end
  end

  // Gyro filter controls follow the stored filter register; first-stage handover follows gyro_stab_processing_en
  always @(posedge sys_clk) begin
    if (srst) begin
      gyro_highpass_enable <= 1'b0;
      gyro_highpass_cutoff <= 2'h0;
      gyro_lowpass_bw <= 2'h0;
      first_lowpass_stage_to_stab <= 1'b0;
    end else begin
      gyro_highpass_enable <= gyro_filt_ff[`SCFC_HP_EN_BIT];
      gyro_highpass_cutoff <= gyro_filt_ff[`SCFC_HP_CUT_LSB +: 2];
      gyro_lowpass_bw <= gyro_filt_ff[`SCFC_LP_BW_LSB +: 2];
      first_lowpass_stage_to_stab <= gyro_stab_processing_en;
    end
  end

  // Accel bandwidth follows the stored register; range follows the decoded nxt_fs (main_accel_fs while main accel is on and scale mode is clear)
  always @(posedge sys_clk) begin
    if (srst) begin
      accel_stab_bandwidth <= 3'h0;
      accel_fs_eff <= `SCFC_FS_2G;
    end else begin
      accel_stab_bandwidth <= accel_cfg_ff[`SCFC_XL_BW_LSB +: 3];
      accel_fs_eff <= nxt_fs;
    end
  end
endmodule

// *** logic/scfc_defines.vh ***
// Constants for the stabilization chain filter configuration bank
// Notes on behaviour
// - Primary-port writes accepted only while primary port owns stabilization control.
// - Gyro high-pass cutoff bits 5:4 select 16m/65m/260m/1.04 Hz; default 00.
// - Gyro high-pass filter applied only while bit 0 is set.
// - Gyro low-pass bits 2:1 select 335.5/232.0/171.1/609.0 Hz cutoff.
// - Accel full scale bits 7:6 decoded by scale mode and main power state.
// - Full scale chosen from main side is mirrored to accel_fs_eff while main accel is on and scale mode is clear.
// - Accel bandwidth bits 5:3 select eight typical bandwidths, 289 down to 4.14 Hz.
// - Self-test with clamp-disable clear forces every chain output to 8000h.
// - While gyro stabilization processing is on, first low-pass stage serves it only.
// - Auxiliary copies reset to zero; writable only in auxiliary control mode.
`ifndef SCFC_DEFINES_VH
`define SCFC_DEFINES_VH
`define SCFC_ADDR_GYRO_FILT 8'h71
`define SCFC_ADDR_ACCEL_CFG 8'h72
`define SCFC_RST_VAL 8'h00
`define SCFC_GYRO_WMASK 8'h37
`define SCFC_ACCEL_WMASK 8'hf9
`define SCFC_HP_EN_BIT 0
`define SCFC_LP_BW_LSB 1
`define SCFC_HP_CUT_LSB 4
`define SCFC_CLAMP_DIS_BIT 0
`define SCFC_XL_BW_LSB 3
`define SCFC_XL_FS_LSB 6
`define SCFC_CLAMP_VAL 16'h8000
// Full-scale codes: 0 = 2 g, 1 = 4 g, 2 = 8 g, 3 = 16 g
`define SCFC_FS_2G 2'h0
`define SCFC_FS_4G 2'h1
`define SCFC_FS_8G 2'h2
`define SCFC_FS_16G 2'h3
`endif

// *** testbench/scfc_checker.sv ***
// Port assertions for the stabilization configuration bank
`timescale 1ns/1ps
module scfc_checker (
  input wire sys_clk, srst, primary_port_owns_stab, pri_wr, aux_wr,
  input wire selftest_active, gyro_stab_processing_en, first_lowpass_stage_to_stab,
  input wire gyro_highpass_enable,
  input wire [7:0] pri_addr, pri_wdata, pri_rdata,
  input wire [7:0] aux_addr, aux_wdata, aux_rdata,
  input wire [1:0] gyro_highpass_cutoff, gyro_lowpass_bw, accel_fs_eff,
  input wire [2:0] accel_stab_bandwidth,
  input wire [15:0] gyro_raw, gyro_out, accel_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire pw = primary_port_owns_stab & pri_wr;
  wire aw = !primary_port_owns_stab & aux_wr;
  AST_PRI_WR: assert property (pw && pri_addr == 8'h71 |-> ##2
    gyro_highpass_cutoff == $past(pri_wdata[5:4], 2)) else $error("pw");
  AST_AUX_GY: assert property (aw && aux_addr == 8'h71 |-> ##2
    {gyro_lowpass_bw, gyro_highpass_enable} == $past(aux_wdata[2:0], 2))
    else $error("aw");
  AST_AUX_XL: assert property (aw && aux_addr == 8'h72 |-> ##2
    accel_stab_bandwidth == $past(aux_wdata[5:3], 2)) else $error("bw");
  AST_REFUSE: assert property (pri_wr && !aw && !pw |->
    ##2 $stable(gyro_lowpass_bw)) else $error("refuse");
  AST_CLAMP: assert property (selftest_active && aux_addr == 8'h72 &&
    !aux_rdata[0] && !aux_wr && !pri_wr |=> gyro_out == 16'h8000 &&
    accel_out == 16'h8000) else $error("clamp");
  AST_PASS: assert property (!selftest_active |=>
    gyro_out == $past(gyro_raw)) else $error("pass");
  AST_FIRST_LOWPASS_STAGE: assert property (gyro_stab_processing_en [*3] |->
    first_lowpass_stage_to_stab) else $error("first_lowpass_stage");
  AST_UNMAP: assert property (!(pri_addr inside {8'h71, 8'h72}) |->
    pri_rdata == 8'h00) else $error("unmapped");
  AST_MIRROR: assert property (pri_addr == aux_addr |->
    pri_rdata == aux_rdata) else $error("mirror");
  AST_RST: assert property (disable iff (1'b0) srst |=>
    accel_fs_eff == 2'h0 && aux_rdata == 8'h00) else $error("reset");
  cover property (pw);
  cover property (aw && aux_addr == 8'h72);
  cover property (selftest_active && gyro_out == 16'h8000);
endmodule
bind scfc_stab_cfg scfc_checker i_chk (.*);

// *** testbench/scfc_host_model.sv ***
// Host model driving both register ports
`timescale 1ns/1ps
module scfc_host_model (
  input wire sys_clk, // System clock
  output logic pri_wr, aux_wr, look, // Write strobes, read marker
  output logic [7:0] pri_addr, aux_addr, pri_wdata, aux_wdata // Buses
);
  initial {pri_wr, aux_wr, look, pri_addr, aux_addr} = '0;
  initial {pri_wdata, aux_wdata} = '0;
  task wr(input bit p, input logic [7:0] a, d);
    @(negedge sys_clk);
    {pri_addr, aux_addr} = {a, a};
    d = d & (a == 8'h71 ? 8'h37 : 8'hf9);
    if (p) {pri_wr, pri_wdata} = {1'b1, d};
    else {aux_wr, aux_wdata} = {1'b1, d};
    @(negedge sys_clk);
    // Released data flips so a stale value cannot pass as fresh
    {pri_wr, aux_wr, pri_wdata, aux_wdata} = {2'b0, ~pri_wdata, ~aux_wdata};
  endtask
  task rd(input logic [7:0] a);
    @(negedge sys_clk);
    {pri_addr, aux_addr, look} = {a, a, 1'b1};
    @(negedge sys_clk);
    look = 0;
  endtask
endmodule

// *** testbench/scfc_stab_cfg_tb_top.sv ***
// Self-checking bench for the stabilization configuration bank
`timescale 1ns/1ps
module scfc_stab_cfg_tb_top;
  logic sys_clk = 0, srst = 1, primary_port_owns_stab = 0, selftest_active = 0;
  logic accel_scale_mode = 0, main_accel_on = 0, gyro_stab_processing_en = 0;
  logic [1:0] main_accel_fs = 0, c, gyro_highpass_cutoff, gyro_lowpass_bw;
  logic [15:0] gyro_raw = 0, accel_raw = 0, gyro_out, accel_out;
  logic [31:0] s = 84822, r = 84822;
  logic [7:0] a, e, q[$];
  int n_mismatch = 0, n_tests = 0;
  wire pri_wr, aux_wr, look, gyro_highpass_enable, first_lowpass_stage_to_stab;
  wire [7:0] pri_addr, aux_addr, pri_wdata, aux_wdata, pri_rdata, aux_rdata;
  wire [2:0] accel_stab_bandwidth;
  wire [1:0] accel_fs_eff;
  scfc_stab_cfg i_dut (.*);
  scfc_host_model i_host (.*);
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input logic [15:0] g, x);
    n_tests++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task close_out;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial forever #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    r = nx(r);
    {gyro_raw, accel_raw} = r;
  end
  always @(posedge sys_clk) if (look === 1'b1) begin
    e = q.pop_front();
    chk(pri_rdata, e);
    chk(aux_rdata, e);
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    srst = 0;
    for (int i = 8'h71; i < 8'h74; i++) begin
      q.push_back(8'h00);
      i_host.rd(i);
    end
    $display("reset values done");
    for (int i = 0; i < 16; i++) begin
      s = nx(s);
      {gyro_stab_processing_en, primary_port_owns_stab} = s[2:1];
      a = s[0] ? 8'h72 : 8'h71;
      i_host.wr(s[1], a, s[15:8]);
      i_host.wr(!s[1], a, ~s[15:8]);
      q.push_back(s[15:8] & (s[0] ? 8'hf9 : 8'h37));
      i_host.rd(a);
    end
    $display("port ownership done");
    primary_port_owns_stab = 0;
    for (int k = 0; k < 16; k++) begin
      {accel_scale_mode, main_accel_on, c} = k;
      main_accel_fs = ~c;
      i_host.wr(0, 8'h72, {c, 6'h01});
      repeat (2) @(negedge sys_clk);
      chk(accel_fs_eff, !accel_scale_mode && main_accel_on ? main_accel_fs :
        c == 2'h1 ? {2{!accel_scale_mode}} : c - (c != 0));
    end
    $display("full scale done");
    selftest_active = 1;
    for (int k = 0; k < 2; k++) begin
      i_host.wr(0, 8'h72, k);
      @(posedge sys_clk);
      #1 chk(accel_out, k ? accel_raw : 16'h8000);
    end
    $display("self-test done");
    close_out;
  end
  initial begin
    #1000000 n_mismatch++;
    close_out;
  end
endmodule
